// *** rtl/rsc_params.svh ***
// Constants for the reset source controller: offsets, fields, reset values, counts.
// Assumes a 100 MHz system clock and a separate low-speed oscillator tick input.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_OPTION_BYTE_ADDR 16'hffff
`define RSC_OPTION_ERASED 8'hff
`define RSC_VMON0_DIS_BIT 5
`define RSC_PM0_ADDR 16'h0004
`define RSC_SW_RESET_BIT 3
`define RSC_LOCO_COUNT 6'h20
`define RSC_CPU_DIV_SEL 4'h8
`define RSC_RESET_VECTOR 16'hfffc
`define RSC_RELEASE_CYCLES 4'h4

`endif

// *** rtl/rsc_pkg.sv ***
// Types for the reset source controller.
// Constants live in rsc_params.svh.
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_ST_RESET = 2'b00,
    RSC_ST_COUNT = 2'b01,
    RSC_ST_RELEASE = 2'b11,
    RSC_ST_RUN = 2'b10
  } rsc_state_e;

  typedef struct packed {
    logic pin;
    logic por;
    logic vmon0;
    logic vmon1;
    logic vmon2;
    logic wdt;
    logic sw;
  } rsc_cause_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rsc_bus_s;
endpackage

// *** rtl/rsc_reset_source_controller.sv ***
// Reset source controller: merges seven reset sources into one internal reset.
// Assumes pin and monitor inputs are asynchronous; CPU bus and flash on mclk_in.
`timescale 1ns/1ps
`include "rsc_params.svh"

// Notes on behaviour
// - Seven sources each reset pins, CPU and special-function registers; here only the reset pin forces the ports to inputs.
// - Hardware reset held while the active-low reset pin samples low.
// - Each monitor resets when its own supply detection input reports a fall.
// - Watchdog underflow resets only when watchdog reset generation is selected.
// - Software writing 1 to the software reset bit causes reset.
// - Reset pin low forces ports 0,1,2,6 and listed port 3,4 pins to inputs.
// - Option byte is read-only to the CPU; program writes leave it unchanged.
// - An erased option block makes the option byte read all ones.
// - After power-on or monitor-0 reset, count 32 slow clocks before release.
// - After reset select slow oscillator divided by eight and start at vector.
// - Bit 5 of the option byte disables monitor-0 reset when 1.
module rsc_reset_source_controller (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Reset sources
  input wire logic reset_pin_n_in,
  input wire logic por_in,
  input wire logic vmon0_detect_in,
  input wire logic vmon1_detect_in,
  input wire logic vmon2_detect_in,
  input wire logic wdt_underflow_in,
  input wire logic wdt_reset_sel_in,
  input wire logic loco_tick_in,
  // CPU register access
  input wire rsc_pkg::rsc_bus_s bus_in,
  output logic [7:0] rdata_out,
  // Flash programmer side of the option byte
  input wire logic prog_wr_in,
  input wire logic [7:0] prog_data_in,
  input wire logic prog_erase_in,
  // Reset results
  output logic sys_reset_out,
  output logic port_force_input_out,
  output rsc_pkg::rsc_cause_s cause_out,
  output logic [3:0] cpu_clk_div_out,
  output logic [15:0] reset_vector_out
);
  // Two-flop synchronisers for asynchronous inputs
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] async_raw;
  assign async_raw = {reset_pin_n_in, por_in, vmon0_detect_in, loco_tick_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        sync1[gi] <= async_raw[gi];
        sync2[gi] <= sync1[gi];
      end
    end
  endgenerate

  // Monitors 1 and 2 feed only fast requests, so they sync on their own
  logic [2:1] vsync1;
  logic [2:1] vsync2;
  always_ff @(posedge mclk_in) begin
    vsync1 <= {vmon2_detect_in, vmon1_detect_in};
    vsync2 <= vsync1;
  end

  logic pin_low;
  logic por_s;
  logic vmon0_s;
  logic tick_s;
  logic tick_d;
  assign pin_low = ~sync2[3];
  assign por_s = sync2[2];
  assign vmon0_s = sync2[1];
  assign tick_s = sync2[0];

  // Option byte: non-volatile, only the programmer port alters it
  // No reset: unknown until first programmed or erased
  logic [7:0] option_select_byte;
  always_ff @(posedge mclk_in) begin
    if (prog_erase_in) begin
      option_select_byte <= `RSC_OPTION_ERASED;
    end else if (prog_wr_in) begin
      option_select_byte <= prog_data_in;
    end
  end

  // Disable bit is latched at hardware reset only
  // A newly programmed value takes effect only after the next pin reset or rst_in
  logic vmon0_dis;
  always_ff @(posedge mclk_in) begin
    if (rst_in || pin_low) begin
      vmon0_dis <= option_select_byte[`RSC_VMON0_DIS_BIT];
    end
  end

  function automatic logic addr_hit(input rsc_pkg::rsc_bus_s b, input logic [15:0] a);
    addr_hit = (b.addr == a);
  endfunction

  logic sw_req;
  assign sw_req = bus_in.wr && addr_hit(bus_in, `RSC_PM0_ADDR)
                  && bus_in.wdata[`RSC_SW_RESET_BIT];

  logic vmon0_req;
  logic wdt_req;
  logic slow_req;
  logic fast_req;
  assign vmon0_req = vmon0_s && !vmon0_dis;
  // Same-clock source: no synchroniser, a one-cycle underflow pulse suffices
  assign wdt_req = wdt_underflow_in && wdt_reset_sel_in;
  assign slow_req = por_s || vmon0_req;
  assign fast_req = pin_low || vsync2[1] || vsync2[2] || wdt_req || sw_req;

  // Any request returns the sequencer to its reset state
  logic any_req;
  assign any_req = slow_req || fast_req;

  // Read path; option byte not writable from CPU, reserved reads return zero
  logic [7:0] next_rdata;
  assign next_rdata = (bus_in.rd && addr_hit(bus_in, `RSC_OPTION_BYTE_ADDR))
                      ? option_select_byte : 8'h00;

  // Release sequencer
  // Release waits a few system clocks after the synchronisers settle
  rsc_pkg::rsc_state_e state;
  rsc_pkg::rsc_state_e next_state;
  logic [5:0] loco_cnt;
  logic [3:0] rel_cnt;
  logic tick_rise;
  assign tick_rise = tick_s && !tick_d;

  always_comb begin
    next_state = state;
    case (state)
      rsc_pkg::RSC_ST_RESET: begin
        if (!any_req) begin
          next_state = rsc_pkg::RSC_ST_COUNT;
        end
      end
      rsc_pkg::RSC_ST_COUNT: begin
        if (any_req) begin
          next_state = rsc_pkg::RSC_ST_RESET;
        end else if (loco_cnt == `RSC_LOCO_COUNT) begin
          next_state = rsc_pkg::RSC_ST_RELEASE;
        end
      end
      rsc_pkg::RSC_ST_RELEASE: begin
        if (any_req) begin
          next_state = rsc_pkg::RSC_ST_RESET;
        end else if (rel_cnt == `RSC_RELEASE_CYCLES) begin
          next_state = rsc_pkg::RSC_ST_RUN;
        end
      end
      rsc_pkg::RSC_ST_RUN: begin
        if (any_req) begin
          next_state = rsc_pkg::RSC_ST_RESET;
        end
      end
      default: next_state = rsc_pkg::RSC_ST_RESET;
    endcase
  end

  // Slow count applies only after rst_in and slow-source resets; others skip it
  logic slow_pending;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= rsc_pkg::RSC_ST_RESET;
      loco_cnt <= 6'h00;
      rel_cnt <= 4'h0;
      tick_d <= 1'b0;
      slow_pending <= 1'b1;
    end else begin
      state <= next_state;
      tick_d <= tick_s;
      if (slow_req) begin
        slow_pending <= 1'b1;
      end else if (next_state == rsc_pkg::RSC_ST_RUN) begin
        slow_pending <= 1'b0;
      end
      // Fast resets preload the full count so the slow wait is skipped
      if (state != rsc_pkg::RSC_ST_COUNT) begin
        loco_cnt <= slow_pending ? 6'h00 : `RSC_LOCO_COUNT;
      end else if (tick_rise && loco_cnt != `RSC_LOCO_COUNT) begin
        loco_cnt <= loco_cnt + 6'h01;
      end
      rel_cnt <= (state == rsc_pkg::RSC_ST_RELEASE) ? rel_cnt + 4'h1 : 4'h0;
    end
  end

  // Registered outputs
  rsc_pkg::rsc_cause_s next_cause;
  assign next_cause = '{pin: pin_low, por: por_s, vmon0: vmon0_req, vmon1: vsync2[1],
                        vmon2: vsync2[2], wdt: wdt_req, sw: sw_req};

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sys_reset_out <= 1'b1;
      port_force_input_out <= 1'b1;
      cause_out <= '0;
      rdata_out <= 8'h00;
      cpu_clk_div_out <= `RSC_CPU_DIV_SEL;
      reset_vector_out <= `RSC_RESET_VECTOR;
    end else begin
      sys_reset_out <= (next_state != rsc_pkg::RSC_ST_RUN);
      port_force_input_out <= pin_low;
      rdata_out <= next_rdata;
      if (next_cause != '0) begin
        cause_out <= next_cause;
      end
      if (state != rsc_pkg::RSC_ST_RUN) begin
        cpu_clk_div_out <= `RSC_CPU_DIV_SEL;
        reset_vector_out <= `RSC_RESET_VECTOR;
      end
    end
  end
endmodule

// *** tb/rsc_reset_source_controller_monitor.sv ***
// Assertion checker for the reset source controller ports.
// Assumes bus strobes last one cycle.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_reset_source_controller_monitor (
  // Clock and sources
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic vmon1_detect_in,
  input wire logic vmon2_detect_in,
  input wire logic wdt_underflow_in,
  input wire logic wdt_reset_sel_in,
  input wire rsc_pkg::rsc_bus_s bus_in,
  // Results
  input wire logic [7:0] rdata_out,
  input wire logic sys_reset_out,
  input wire logic port_force_input_out,
  input wire rsc_pkg::rsc_cause_s cause_out,
  input wire logic [3:0] cpu_clk_div_out,
  input wire logic [15:0] reset_vector_out
);
  wire sw_wr = bus_in.wr && bus_in.addr == `RSC_PM0_ADDR && bus_in.wdata[`RSC_SW_RESET_BIT];
  wire wdt_go = wdt_underflow_in && wdt_reset_sel_in;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  chk_pin_reset: assert property (!reset_pin_n_in [*5] |-> sys_reset_out)
    else $error("pin low without reset");
  chk_pin_force: assert property (!reset_pin_n_in [*5] |-> port_force_input_out)
    else $error("pins not forced to input");
  chk_mon_reset: assert property ((vmon1_detect_in || vmon2_detect_in) [*5] |-> sys_reset_out)
    else $error("monitor without reset");
  chk_wdt_reset: assert property (wdt_go |=> sys_reset_out && cause_out.wdt)
    else $error("watchdog without reset");
  chk_sw_reset: assert property (sw_wr |=> sys_reset_out && cause_out.sw)
    else $error("software write without reset");
  chk_div_vector: assert property (sys_reset_out |-> cpu_clk_div_out == `RSC_CPU_DIV_SEL
    && reset_vector_out == `RSC_RESET_VECTOR)
    else $error("clock or vector wrong in reset");
  chk_release_clean: assert property ($fell(sys_reset_out) |-> $past(reset_pin_n_in, 3)
    && !$past(wdt_go))
    else $error("release with request pending");
  chk_read_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data without read");
  cover property ($fell(sys_reset_out));
  cover property (sw_wr);
  cover property (wdt_go);
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_monitor i_mon (.mclk_in, .rst_in,
  .reset_pin_n_in, .vmon1_detect_in, .vmon2_detect_in, .wdt_underflow_in, .wdt_reset_sel_in,
  .bus_in, .rdata_out, .sys_reset_out, .port_force_input_out, .cause_out, .cpu_clk_div_out,
  .reset_vector_out);

// *** tb/rsc_source_model.sv ***
// Partner model: external reset pin driver and slow oscillator.
// Assumes pulse_in is raised on the same clock as clk_in.
`timescale 1ns/1ps
module rsc_source_model #(parameter int HOLD = 1000) (
  // Clock and request
  input wire logic clk_in,
  input wire logic pulse_in,
  // Pin and oscillator
  output logic pin_n_out,
  output logic tick_out
);
  int cnt = 0;
  // Oscillator runs free, unrelated in phase to clk_in
  initial begin
    tick_out = 1'b0;
    forever #35.3 tick_out = ~tick_out;
  end
  always @(posedge clk_in) cnt <= pulse_in ? HOLD : (cnt > 0 ? cnt - 1 : 0);
  assign pin_n_out = (cnt == 0); // Low for 10 us at 100 MHz
endmodule

// *** tb/test_rsc_reset_source_controller.sv ***
// Self-checking bench for the reset source controller.
// Assumes the partner model supplies the reset pin and slow oscillator.
`timescale 1ns/1ps
`include "rsc_params.svh"
module test_rsc_reset_source_controller;
  logic mclk_in = 0, rst_in = 1, por, vm0, vm1, vm2, wdt, wsel, pulse, pin_n, tick;
  logic prog_wr, prog_erase, sys_rst, force_in;
  logic [7:0] prog_data, rdata, ob;
  logic [3:0] div;
  logic [15:0] vec;
  rsc_pkg::rsc_bus_s bus;
  rsc_pkg::rsc_cause_s cause;
  int failures = 0, tests_run = 0, seed = 71347, n;
  rsc_source_model i_rsc_source_model (.clk_in(mclk_in), .pulse_in(pulse), .pin_n_out(pin_n),
    .tick_out(tick));
  rsc_reset_source_controller i_rsc_reset_source_controller (.mclk_in, .rst_in,
    .reset_pin_n_in(pin_n), .por_in(por), .vmon0_detect_in(vm0), .vmon1_detect_in(vm1),
    .vmon2_detect_in(vm2), .wdt_underflow_in(wdt), .wdt_reset_sel_in(wsel), .loco_tick_in(tick),
    .bus_in(bus), .rdata_out(rdata), .prog_wr_in(prog_wr), .prog_data_in(prog_data),
    .prog_erase_in(prog_erase), .sys_reset_out(sys_rst), .port_force_input_out(force_in),
    .cause_out(cause), .cpu_clk_div_out(div), .reset_vector_out(vec));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    bus = '{w, !w, a, w ? d : 8'h00};
    cyc(1);
    if (!w) chk("rdata", d, rdata);
    // Idle one cycle so back-to-back calls never retarget the bus in one step
    bus = '0;
    cyc(1);
  endtask
  // Power-on, and monitor 0 when enabled, wait for the slow count
  function automatic logic exp_slow(input int k, input logic [7:0] o);
    exp_slow = (k == 1) || (k == 2 && !o[`RSC_VMON0_DIS_BIT]);
  endfunction
  task automatic wait_rel(output int c);
    c = 0;
    while (sys_rst !== 1'b0 && c < 3000) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic src(input int k, input logic v);
    case (k)
      0: pulse = v;
      1: por = v;
      2: vm0 = v;
      3: vm1 = v;
      4: vm2 = v;
      5: wdt = v;
      default: if (v) acc(1, `RSC_PM0_ADDR, 8'h01 << `RSC_SW_RESET_BIT);
    endcase
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #5 mclk_in = ~mclk_in;
  initial begin
    #300us;
    failures++;
    finish_test;
  end
  initial begin
    {por, vm0, vm1, vm2, wdt, wsel, pulse, prog_wr, prog_data} = '0;
    bus = '0;
    // Erase during reset so monitor 0 starts disabled
    prog_erase = 1;
    cyc(12);
    {prog_erase, rst_in} = '0;
    wait_rel(n);
    chk("released", 0, sys_rst);
    chk("dwell", 1, n >= 220);
    acc(0, `RSC_OPTION_BYTE_ADDR, `RSC_OPTION_ERASED);
    acc(1, `RSC_OPTION_BYTE_ADDR, 8'h00);
    acc(0, `RSC_OPTION_BYTE_ADDR, `RSC_OPTION_ERASED);
    acc(0, 16'h0180, 8'h00);
    {vm0, wdt} = 2'b11;
    cyc(8);
    chk("no reset", 0, sys_rst);
    {vm0, wdt} = 2'b00;
    ob = $random(seed);
    ob[`RSC_VMON0_DIS_BIT] = 1'b0;
    {prog_data, prog_wr} = {ob, 1'b1};
    cyc(1);
    prog_wr = 0;
    acc(0, `RSC_OPTION_BYTE_ADDR, ob);
    // Pin first, so the new monitor-0 setting is sampled
    for (int k = 0; k < 7; k++) begin
      wsel = (k == 5) ? 1'b1 : 1'($random(seed));
      src(k, 1);
      cyc(5);
      chk("reset", 1, sys_rst);
      chk("div", `RSC_CPU_DIV_SEL, div);
      chk("vector", `RSC_RESET_VECTOR, vec);
      chk("cause", 1, cause[6 - k]);
      chk("force", k == 0, force_in);
      src(k, 0);
      wait_rel(n);
      chk("released", 0, sys_rst);
      if (k != 0) chk("dwell", exp_slow(k, ob), n >= 220);
    end
    finish_test;
  end
endmodule
